// ---- wdrc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDRC_DEFS_SVH
`define WDRC_DEFS_SVH

// Register indices as printed; the byte address is four times the index
`define WDRC_IDX_CAUSE 12'h055
`define WDRC_IDX_CTRL 12'h060
`define WDRC_ADDR_CAUSE (`WDRC_IDX_CAUSE * 4)
`define WDRC_ADDR_CTRL (`WDRC_IDX_CTRL * 4)

// Reset-cause register fields
`define WDRC_CAUSE_POWER_ON 0
`define WDRC_CAUSE_PIN 1
`define WDRC_CAUSE_BROWNOUT 2
`define WDRC_CAUSE_WDOG 3

// Watchdog control register fields
`define WDRC_CTRL_SEL0 0
`define WDRC_CTRL_SEL2 2
`define WDRC_CTRL_RESET_EN 3
`define WDRC_CTRL_UNLOCK 4
`define WDRC_CTRL_SEL3 5
`define WDRC_CTRL_IRQ_EN 6
`define WDRC_CTRL_IRQ_FLAG 7

// Reset values
`define WDRC_CAUSE_RESET 4'h1
`define WDRC_SEL_RESET 4'h0

// Timing
`define WDRC_UNLOCK_CYCLES 3'h4
`define WDRC_BASE_PERIOD 2048
`define WDRC_SEL_LAST 4'h9

`endif

// ---- wdrc_pkg.sv ----
// Types shared by the watchdog block
package wdrc_pkg;

   // Operating mode, one-hot
   typedef enum logic [3:0] {
      MODE_STOPPED = 4'b0001,
      MODE_IRQ = 4'b0010,
      MODE_RESET = 4'b0100,
      MODE_IRQ_RESET = 4'b1000
   } wdrc_mode_t;

   // Control register contents
   typedef struct packed {
      logic irq_flag;
      logic irq_enable;
      logic unlock;
      logic reset_enable;
      logic [3:0] timeout_select;
   } wdrc_ctrl_t;

   // Reset-cause flags
   typedef struct packed {
      logic wdog;
      logic brownout;
      logic pin;
      logic power_on;
   } wdrc_cause_t;

endpackage

// ---- wdrc_counter.sv ----
// Watchdog time-out counter stepped by the low-frequency oscillator
`timescale 1ns/10ps
`include "wdrc_defs.svh"

module wdrc_counter #(
   parameter int unsigned BASE_PERIOD = `WDRC_BASE_PERIOD
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_en,
   input wire logic osc_level,
   input wire logic run,
   input wire logic restart,
   input wire logic [3:0] timeout_select,
   output logic timeout_pulse
);

   logic osc_prev_reg; // Oscillator level one cycle ago
   logic [19:0] count_reg; // Oscillator cycles seen
   logic osc_rise; // Oscillator rising edge

   // Last count value before time-out for a select code
   function automatic logic [19:0] terminal_of(input logic [3:0] sel);
      logic [3:0] s;
      logic [20:0] period;
      s = (sel > `WDRC_SEL_LAST) ? `WDRC_SEL_LAST : sel;
      period = 21'(BASE_PERIOD) << s;
      return 20'(period - 21'h000001);
   endfunction

   assign osc_rise = osc_level & ~osc_prev_reg;

   // Oscillator edge detector
   always_ff @(posedge clock) begin
      if (reset) begin
         osc_prev_reg <= 1'b0;
      end else if (clock_en) begin
         osc_prev_reg <= osc_level;
      end
   end

   // Counter and time-out pulse
   always_ff @(posedge clock) begin
      if (reset) begin
         count_reg <= 20'h00000;
         timeout_pulse <= 1'b0;
      end else if (clock_en) begin
         timeout_pulse <= 1'b0;
         if (restart || !run) begin
            // Restart strobe clears the count
            count_reg <= 20'h00000; // R23
         end else if (osc_rise) begin
            // Period doubles per select step
            if (count_reg >= terminal_of(timeout_select)) begin // R15
               count_reg <= 20'h00000;
               timeout_pulse <= 1'b1;
            end else begin
               count_reg <= count_reg + 20'h00001; // R20
            end
         end
      end
   end

endmodule

// ---- wdrc_top.sv ----
// Watchdog timer with reset-cause flags behind an APB slave
//
// Functional notes
// (R01) Reset-cause bits 7:4 read zero
// (R02) Watchdog flag set on watchdog reset
// (R03) Brown-out flag set on brown-out event
// (R04) Pin flag set on external reset
// (R05) Power-on flag cleared only by software
// (R06) Interrupt flag: timeout sets, vector clears
// (R07) Interrupt needs global and local enable
// (R08) Vector in combined mode drops interrupt enable
// (R09) Unserviced interrupt then next timeout resets
// (R10) Mode from reset and interrupt enables
// (R11) Programmed fuse forces reset mode
// (R12) Clear enable, change select need unlock
// (R13) Unlock clears itself four cycles later
// (R14) Reset enable reads set while flag set
// (R15) Select gives 2048 to 1048576 cycles
// (R16) Software restarts counter before select change
// (R17) Init software clears flag and enable
// (R18) Software reads then clears reset causes
// (R19) Unlock write, then settings within four
// (R20) Counter runs on separate oscillator
// (R21) Fuse holds enable one, interrupt zero
// (R22) Watchdog reset pulse is one cycle
// (R23) Restart strobe clears counter
// (R24) Cause writes of one leave flags
`timescale 1ns/10ps
`include "wdrc_defs.svh"

module wdrc_top #(
   parameter int unsigned BASE_PERIOD = `WDRC_BASE_PERIOD
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_level,
   input wire logic restart_strobe,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire logic pin_reset_event,
   input wire logic brownout_event,
   input wire logic always_on_fuse,
   output logic wdog_irq,
   output logic wdog_sys_reset
);

   wdrc_pkg::wdrc_ctrl_t ctrl_reg; // Control register state
   wdrc_pkg::wdrc_cause_t cause_reg; // Reset-cause flags
   logic [2:0] unlock_count_reg; // Cycles left in unlock window
   wdrc_pkg::wdrc_mode_t mode; // Effective operating mode
   logic fuse_on; // Fuse programmed (reads 0)
   logic reset_en_eff; // Reset enable as seen by logic
   logic irq_en_eff; // Interrupt enable as seen by logic
   logic timeout; // Time-out pulse from counter
   logic wdog_fire; // Watchdog system reset this cycle
   logic irq_set; // Time-out sets interrupt flag
   logic bus_setup_ok; // Access phase, answer not yet given
   logic bus_done; // Transfer completes at this edge
   logic wr_cause; // Write to reset-cause register
   logic wr_ctrl; // Write to control register
   logic hit_cause; // Address matches reset-cause register
   logic hit_ctrl; // Address matches control register
   logic [7:0] cause_rd; // Reset-cause read value
   logic [7:0] ctrl_rd; // Control read value
   logic [7:0] wbyte; // Low byte of write data

   assign wbyte = pwdata[7:0];

   // Address decode against register byte address
   // Only the low byte of write data reaches the registers
   // Upper write bits are dropped without an error
   // Reads fill bits 31:8 with zero
   // Unmapped addresses answer with an error
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
      return a == target;
   endfunction

   assign hit_cause = addr_is(paddr, 12'(`WDRC_ADDR_CAUSE));
   assign hit_ctrl = addr_is(paddr, 12'(`WDRC_ADDR_CTRL));

   // Fuse and enable overrides
   // Programmed fuse shows as a low level on its pin
   // Watchdog flag keeps reset enable visible as set
   // Software cannot leave reset mode before clearing it
   // Interrupt enable reads zero under the fuse
   always_comb begin
      fuse_on = ~always_on_fuse; // R11
      // Fuse locks enables
      reset_en_eff = ctrl_reg.reset_enable | cause_reg.wdog | fuse_on; // R14 R21
      irq_en_eff = ctrl_reg.irq_enable & ~fuse_on; // R21
   end

   // Mode table
   // Stopped holds the counter at zero
   // Interrupt mode only raises the flag
   // Reset mode pulses the system reset
   // Combined mode interrupts first, resets on the next
   always_comb begin
      if (fuse_on) begin
         mode = wdrc_pkg::MODE_RESET; // R11
      end else begin
         unique case ({reset_en_eff, irq_en_eff}) // R10
            2'b00: mode = wdrc_pkg::MODE_STOPPED;
            2'b01: mode = wdrc_pkg::MODE_IRQ;
            2'b10: mode = wdrc_pkg::MODE_RESET;
            2'b11: mode = wdrc_pkg::MODE_IRQ_RESET;
         endcase
      end
   end

   // Time-out action by mode
   // Decided in the cycle of the counter pulse
   // Uses the flag as it stood before this edge
   // A vector in the same cycle cannot stop the reset
   // Interrupt mode keeps a flag that is already set
   always_comb begin
      wdog_fire = 1'b0;
      irq_set = 1'b0;
      if (timeout) begin
         unique case (mode)
            // No action while stopped
            wdrc_pkg::MODE_STOPPED: irq_set = 1'b0;
            // Interrupt only
            wdrc_pkg::MODE_IRQ: irq_set = 1'b1; // R06
            // Reset only
            wdrc_pkg::MODE_RESET: wdog_fire = 1'b1;
            // First time-out interrupts, unserviced second resets
            wdrc_pkg::MODE_IRQ_RESET: begin
               if (ctrl_reg.irq_flag) begin
                  wdog_fire = 1'b1; // R09
               end else begin
                  irq_set = 1'b1; // R08
               end
            end
         endcase
      end
   end

   // Counter on the oscillator edge
   // Oscillator level sampled on the system clock
   // Restart strobe and stopped mode both clear it
   // Reserved select codes act as the longest period
   // Counter freezes with the clock enable
   wdrc_counter #(
      .BASE_PERIOD(BASE_PERIOD)
   ) u_counter (
      .clock(clock),
      .reset(reset),
      .clock_en(clock_en),
      .osc_level(osc_level),
      .run(mode != wdrc_pkg::MODE_STOPPED),
      .restart(restart_strobe),
      .timeout_select(ctrl_reg.timeout_select),
      .timeout_pulse(timeout)
   );

   // APB handshake: answer one cycle into the access phase
   // Three cycles per transfer, setup cycle included
   // Ready is a one-cycle pulse, never held
   // Side effects happen only at the completion edge
   // Back-to-back transfers need no idle cycle
   assign bus_setup_ok = psel & penable & ~pready;
   assign bus_done = psel & penable & pready;
   assign wr_cause = bus_done & pwrite & hit_cause;
   assign wr_ctrl = bus_done & pwrite & hit_ctrl;

   // Read values
   // Effective enables are read, not the stored bits
   // Unlock bit reads back while its window is open
   // Reserved select codes read back as written
   always_comb begin
      cause_rd = {4'h0, cause_reg}; // R01
      ctrl_rd = 8'h00;
      ctrl_rd[`WDRC_CTRL_IRQ_FLAG] = ctrl_reg.irq_flag;
      ctrl_rd[`WDRC_CTRL_IRQ_EN] = irq_en_eff;
      ctrl_rd[`WDRC_CTRL_SEL3] = ctrl_reg.timeout_select[3];
      ctrl_rd[`WDRC_CTRL_UNLOCK] = ctrl_reg.unlock;
      ctrl_rd[`WDRC_CTRL_RESET_EN] = reset_en_eff; // R14
      ctrl_rd[`WDRC_CTRL_SEL2:`WDRC_CTRL_SEL0] = ctrl_reg.timeout_select[2:0];
   end

   // Ready, error and read data
   // Read data returns to zero after the answer
   // Error shares the pulse of ready
   // All three frozen with the clock enable
   always_ff @(posedge clock) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clock_en) begin
         pready <= bus_setup_ok;
         // Unmapped address answers with error
         pslverr <= bus_setup_ok & ~(hit_cause | hit_ctrl);
         if (bus_setup_ok && !pwrite && hit_cause) begin
            prdata <= {24'h000000, cause_rd};
         end else if (bus_setup_ok && !pwrite && hit_ctrl) begin
            prdata <= {24'h000000, ctrl_rd};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Reset-cause flags; hardware events win over a write
   // Writing zero clears, writing one keeps
   // Event in the clearing cycle keeps its flag
   // Power-on flag has no hardware set outside reset
   // Reserved upper write bits have no effect
   always_ff @(posedge clock) begin
      if (reset) begin
         // Power-on sets only its own flag
         cause_reg <= `WDRC_CAUSE_RESET; // R05
      end else if (clock_en) begin
         if (wr_cause) begin
            // Zero clears, one leaves, upper bits ignored
            cause_reg.power_on <= cause_reg.power_on & wbyte[`WDRC_CAUSE_POWER_ON]; // R05 R24
            cause_reg.pin <= (cause_reg.pin & wbyte[`WDRC_CAUSE_PIN]) | pin_reset_event; // R04
            cause_reg.brownout <= (cause_reg.brownout & wbyte[`WDRC_CAUSE_BROWNOUT])
                                  | brownout_event; // R03
            cause_reg.wdog <= (cause_reg.wdog & wbyte[`WDRC_CAUSE_WDOG]) | wdog_fire; // R02
         end else begin
            // Events set their flags
            cause_reg.pin <= cause_reg.pin | pin_reset_event; // R04
            cause_reg.brownout <= cause_reg.brownout | brownout_event; // R03
            cause_reg.wdog <= cause_reg.wdog | wdog_fire; // R02
         end
      end
   end

   // Unlock window timer
   // Window lasts four enabled cycles
   // A second opening write restarts the window
   // Writing zero to unlock does not close it early
   // Later writes inside the window still load settings
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg.unlock <= 1'b0;
         unlock_count_reg <= 3'h0;
      end else if (clock_en) begin
         if (wr_ctrl && wbyte[`WDRC_CTRL_UNLOCK]) begin
            // Opening write of the timed sequence
            ctrl_reg.unlock <= 1'b1; // R19
            unlock_count_reg <= `WDRC_UNLOCK_CYCLES;
         end else if (unlock_count_reg == 3'h1) begin
            // Window closes by itself
            ctrl_reg.unlock <= 1'b0; // R13
            unlock_count_reg <= 3'h0;
         end else if (unlock_count_reg != 3'h0) begin
            unlock_count_reg <= unlock_count_reg - 3'h1; // R13
         end
      end
   end

   // Reset enable and time-out select
   // Setting reset enable needs no unlock
   // Clearing waits for unlock and a clear watchdog flag
   // Select changes outside the window are dropped
   // Fuse wins over any write of reset enable
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg.reset_enable <= 1'b0;
         ctrl_reg.timeout_select <= `WDRC_SEL_RESET;
      end else if (clock_en) begin
         if (fuse_on) begin
            ctrl_reg.reset_enable <= 1'b1; // R21
         end else if (wr_ctrl && wbyte[`WDRC_CTRL_RESET_EN]) begin
            // Setting is always allowed
            ctrl_reg.reset_enable <= 1'b1;
         end else if (wr_ctrl && ctrl_reg.unlock && !cause_reg.wdog) begin
            // Clearing needs unlock and a clear watchdog flag
            ctrl_reg.reset_enable <= 1'b0; // R12 R14
         end
         if (wr_ctrl && ctrl_reg.unlock) begin
            // Select changes only inside the window
            ctrl_reg.timeout_select <= {wbyte[`WDRC_CTRL_SEL3],
                                        wbyte[`WDRC_CTRL_SEL2:`WDRC_CTRL_SEL0]}; // R12
         end
      end
   end

   // Interrupt enable
   // Fuse keeps it at zero
   // Vector in combined mode drops back to reset mode
   // Plain interrupt mode keeps it across vectors
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg.irq_enable <= 1'b0;
      end else if (clock_en) begin
         if (fuse_on) begin
            ctrl_reg.irq_enable <= 1'b0; // R21
         end else if (irq_vector_ack && reset_en_eff) begin
            // Vector in combined mode falls back to reset mode
            ctrl_reg.irq_enable <= 1'b0; // R08
         end else if (wr_ctrl) begin
            ctrl_reg.irq_enable <= wbyte[`WDRC_CTRL_IRQ_EN];
         end
      end
   end

   // Interrupt flag; a time-out wins over any clear
   // Vector and a write of one both clear
   // Set wins so that no time-out is lost
   // Write of zero leaves it as it is
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg.irq_flag <= 1'b0;
      end else if (clock_en) begin
         if (irq_set) begin
            ctrl_reg.irq_flag <= 1'b1; // R06
         end else if (irq_vector_ack) begin
            // Vector execution clears
            ctrl_reg.irq_flag <= 1'b0; // R06 R08
         end else if (wr_ctrl && wbyte[`WDRC_CTRL_IRQ_FLAG]) begin
            // Write of one clears
            ctrl_reg.irq_flag <= 1'b0; // R06
         end
      end
   end

   // Interrupt request and system reset outputs
   // Request lags the flag by one cycle
   // Reset pulse is one cycle wide
   // Reset pulse does not reset this block
   // System logic must reset it only at power-on
   always_ff @(posedge clock) begin
      if (reset) begin
         wdog_irq <= 1'b0;
         wdog_sys_reset <= 1'b0;
      end else if (clock_en) begin
         // Request only with both enables set
         wdog_irq <= ctrl_reg.irq_flag & irq_en_eff & global_irq_enable; // R07
         // Single-cycle reset pulse
         wdog_sys_reset <= wdog_fire; // R22
      end
   end

endmodule

// ---- wdrc_checker.sv ----
// Port assertions of the watchdog block, bound to its top module
`timescale 1ns/10ps
`include "wdrc_defs.svh"
module wdrc_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_enable,
   input wire logic always_on_fuse,
   input wire logic wdog_irq,
   input wire logic wdog_sys_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [3:0] since_unlock; // Cycles since an unlock write completed
   wire logic rd_done = psel && penable && pready && !pwrite; // Read answered
   // Age of the last unlock write, saturating
   always_ff @(posedge clock) begin
      if (reset) begin
         since_unlock <= 4'hf;
      end else if (psel && penable && pready && pwrite && pwdata[4]
                   && paddr == 12'(`WDRC_ADDR_CTRL)) begin
         since_unlock <= 4'h0;
      end else if (clock_en && since_unlock != 4'hf) begin
         since_unlock <= since_unlock + 4'h1;
      end
   end
   a_cause_upper_zero: assert property (rd_done && paddr == 12'(`WDRC_ADDR_CAUSE)
      |-> prdata[31:4] == 28'h0)
      else $error("reset cause upper bits not zero");
   a_reset_one_cycle: assert property (wdog_sys_reset |=> !wdog_sys_reset)
      else $error("watchdog reset pulse longer than one cycle");
   a_irq_needs_global: assert property (clock_en && !global_irq_enable |=> !wdog_irq)
      else $error("interrupt without global enable");
   a_fuse_blocks_irq: assert property (clock_en && !always_on_fuse |=> !wdog_irq)
      else $error("interrupt while fuse forces reset mode");
   a_fuse_locks_bits: assert property (rd_done && paddr == 12'(`WDRC_ADDR_CTRL)
      && !always_on_fuse && !$past(always_on_fuse) |-> prdata[3] && !prdata[6])
      else $error("fuse does not lock enable bits");
   a_unlock_expires: assert property (rd_done && paddr == 12'(`WDRC_ADDR_CTRL)
      && since_unlock > 4'h7 |-> !prdata[4])
      else $error("unlock bit still set after window");
   a_access_answer: assert property (clock_en && psel && penable && !pready |=> pready)
      else $error("access not answered next cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule

bind wdrc_top wdrc_checker i_wdrc_checker (.clock(clock), .reset(reset), .clock_en(clock_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
   .always_on_fuse(always_on_fuse), .wdog_irq(wdog_irq), .wdog_sys_reset(wdog_sys_reset));

// ---- wdrc_partner.sv ----
// Oscillator and vector-executing core facing the watchdog
`timescale 1ns/10ps
module wdrc_partner (
   input wire logic clock,
   input wire logic reset,
   input wire logic ack_on,
   input wire logic wdog_irq,
   output logic osc_level,
   output logic irq_vector_ack
);
   logic [2:0] osc_div; // Half-period count
   logic [1:0] cool; // Quiet time after a vector
   // Free-running slow oscillator, five clocks per half period
   always_ff @(posedge clock) begin
      if (reset || osc_div == 3'h4) begin
         osc_div <= 3'h0;
         osc_level <= reset ? 1'b0 : !osc_level;
      end else begin
         osc_div <= osc_div + 3'h1;
      end
   end
   // One vector per request, then three quiet cycles before the next
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_vector_ack <= 1'b0;
         cool <= 2'h0;
      end else if (cool != 2'h0) begin
         irq_vector_ack <= 1'b0;
         cool <= cool - 2'h1;
      end else begin
         irq_vector_ack <= ack_on && wdog_irq;
         cool <= (ack_on && wdog_irq) ? 2'h3 : 2'h0;
      end
   end
endmodule

// ---- wdrc_bench.sv ----
// Self-checking bench of the watchdog block
`timescale 1ns/10ps
`include "wdrc_defs.svh"
module wdrc_bench;
   localparam int BP = 4; // Shortened base period
   localparam int OSC = 10; // Clocks per oscillator edge
   localparam logic [11:0] CA = 12'(`WDRC_ADDR_CAUSE);
   localparam logic [11:0] CT = 12'(`WDRC_ADDR_CTRL);
   logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q, v;
   logic pready, pslverr, osc_level, ack, irq, srst, e;
   logic strobe = 1'b0, gie = 1'b0, pin_ev = 1'b0, bo_ev = 1'b0, fuse = 1'b1, ack_on = 1'b0;
   logic [3:0] s;
   logic ce = 1'b1; // Clock enable of the block
   logic [3:0] sels [4] = '{4'h0, 4'h1, 4'h3, 4'ha}; // Last one is reserved
   int failures = 0, comparisons = 0, cycles = 0, resets = 0, n, t;
   int cause_m; // Model of the reset-cause flags
   initial begin
      forever #5 clock = !clock;
   end
   wdrc_top #(.BASE_PERIOD(BP)) i_wdrc_top (.clock(clock), .reset(reset), .clock_en(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_level(osc_level),
      .restart_strobe(strobe), .global_irq_enable(gie), .irq_vector_ack(ack),
      .pin_reset_event(pin_ev), .brownout_event(bo_ev), .always_on_fuse(fuse),
      .wdog_irq(irq), .wdog_sys_reset(srst));
   wdrc_partner i_wdrc_partner (.clock(clock), .reset(reset), .ack_on(ack_on),
      .wdog_irq(irq), .osc_level(osc_level), .irq_vector_ack(ack));
   // Hang guard and reset pulse tally
   always @(posedge clock) begin
      cycles <= cycles + 1;
      resets <= resets + 32'(srst === 1'b1);
      if (cycles == 60000) begin
         failures = failures + 1;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] x, input logic [31:0] got);
      comparisons++;
      if (got !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, x, got);
      end
   endtask
   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rq, output logic re);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0, q, e);
      check(nm, x, q);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask
   task automatic por();
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      cause_m = 1;
   endtask
   task automatic pulse();
      @(posedge clock);
      strobe <= 1'b1;
      @(posedge clock);
      strobe <= 1'b0;
   endtask
   // Cycles until the interrupt or the reset shows, up to a limit
   task automatic wait_for(input logic want, input int lim, output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while ((want ? srst : irq) !== 1'b1 && c < lim);
   endtask
   initial begin
      void'($urandom(32'h3575));
      por();
      rd(CA, 32'h1, "cause reset");
      rd(CT, 32'h0, "ctrl reset");
      for (int i = 0; i < 8; i++) begin
         v = $urandom();
         @(posedge clock);
         pin_ev <= v[8];
         bo_ev <= v[9];
         @(posedge clock);
         pin_ev <= 1'b0;
         bo_ev <= 1'b0;
         cause_m = (cause_m | {v[9:8], 1'b0}) & {28'h0, v[3:0]};
         wr(CA, v);
         rd(CA, cause_m, "cause flags");
      end
      apb(1'b0, 12'h100, 32'h0, q, e);
      check("unmapped", 32'h1, {31'h0, e} | q);
      $display("test cause done");
      por();
      gie <= 1'b1;
      wr(CT, 32'h40);
      pulse();
      wait_for(1'b0, 500, n);
      check("irq seen", 32'h1, 32'(n < 500));
      rd(CT, 32'hc0, "irq flag");
      wr(CT, 32'hc0);
      rd(CT, 32'h40, "flag cleared");
      gie <= 1'b0;
      wait_for(1'b0, 200, n);
      check("masked", 32'd200, n);
      rd(CT, 32'hc0, "masked flag");
      wr(CT, 32'h00);
      wr(CT, 32'h80);
      repeat (200) @(posedge clock);
      rd(CT, 32'h0, "stopped");
      check("no reset", 32'h0, resets);
      $display("test interrupt done");
      for (int a = 1; a >= 0; a--) begin
         por();
         gie <= 1'b1;
         ack_on <= a[0];
         wr(CT, 32'h48);
         pulse();
         wait_for(1'b1, 500, n);
         check("reset time", 32'h1, 32'(n > 60 && n < 100));
         rd(CT, a ? 32'h08 : 32'hc8, "combined");
         rd(CA, 32'h09, "wdog flag");
         pulse();
         wr(CT, 32'h18);
         wr(CT, 32'h00);
         rd(CT, a ? 32'h08 : 32'h88, "enable held");
         pulse();
         wr(CA, 32'h0);
         wr(CT, 32'h18);
         wr(CT, 32'h80);
         rd(CT, 32'h0, "enable cleared");
         rd(CA, 32'h0, "cause cleared");
      end
      $display("test combined done");
      por();
      ack_on <= 1'b0;
      wr(CT, 32'h41);
      rd(CT, 32'h40, "locked select");
      repeat (10) begin
         pulse();
         repeat (15) @(posedge clock);
      end
      rd(CT, 32'h40, "restarted");
      pulse();
      ce <= 1'b0;
      repeat (60) @(posedge clock);
      ce <= 1'b1;
      rd(CT, 32'h40, "frozen");
      foreach (sels[i]) begin
         s = sels[i];
         pulse();
         wr(CT, 32'h18);
         wr(CT, {24'h0, 2'b11, s[3], 2'b00, s[2:0]});
         pulse();
         wait_for(1'b0, 25000, n);
         t = (BP * OSC) << ((s > 4'h9) ? 9 : s);
         check("period", 32'h1, 32'(n > t - 12 && n < t + 16));
         rd(CT, {24'h0, 2'b11, s[3], 2'b00, s[2:0]}, "select");
      end
      $display("test select done");
      fuse <= 1'b0;
      por();
      rd(CT, 32'h08, "fuse ctrl");
      wr(CT, 32'h40);
      rd(CT, 32'h08, "fuse lock");
      pulse();
      wait_for(1'b1, 100, n);
      check("fuse reset", 32'h1, 32'(n < 100));
      $display("test fuse done");
      complete_run();
   end
endmodule
